// ### hw/sls_serial_link.v
// Byte-wide serial link unit: status, data buffer, select pin and shifter.
// Assumes a classic Wishbone master and pins resolved outside from enables.
`timescale 1ns/1ns
`default_nettype none
`include "sls_defs.vh"
module sls_serial_link (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Shift clock pin
  input wire sclk_i,
  output wire sclk_o,
  output wire sclk_oe,
  // Master out, slave in
  input wire mosi_i,
  output wire mosi_o,
  output wire mosi_oe,
  // Master in, slave out
  input wire miso_i,
  output wire miso_o,
  output wire miso_oe,
  // Slave select pin, active low on the wire
  input wire ss_n_i,
  output wire ss_n_o,
  output wire ss_n_oe,
  // Select pin handed to general purpose port logic
  output wire ss_gpio_mode,
  // Interrupt request
  output wire irq
);
  // Register state
  reg [7:0] ctrl_q; // Control byte
  reg fault_det_dis_q; // Fault detect disable
  reg complete_flag_q; // Transfer complete
  reg collision_flag_q; // Write collision
  reg ovf_q; // Receive overrun
  reg mode_fault_q; // Mode fault
  reg [1:0] ien_q; // Global and serial interrupt enables
  reg [7:0] shreg_q; // Shift register
  reg [7:0] rxbuf_q; // Receive read buffer
  // Shifter state
  reg busy_q; // Byte in progress or slave selected
  reg [3:0] edge_q; // Shift clock edges done in this byte
  reg sin_q; // Bit sampled, waiting for shift edge
  reg lvl_q; // Master clock phase, zero at idle
  reg sclk_prev_q; // Previous slave clock level
  // Bus answer and pin registers
  reg ack_q;
  reg [7:0] rdat_q;
  reg sclk_o_q, sclk_oe_q, mosi_o_q, mosi_oe_q, miso_o_q, miso_oe_q;
  reg ss_o_q, ss_oe_q, gpio_q, irq_q;

  // Synchronised pin inputs
  wire sclk_s, mosi_s, miso_s, ss_n_s;
  sls_sync2 #(.WIDTH(4)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in({sclk_i, mosi_i, miso_i, ss_n_i}),
    .sync_out({sclk_s, mosi_s, miso_s, ss_n_s})
  );

  // Control fields
  wire en = ctrl_q[`SLS_C_EN];
  wire master_select = ctrl_q[`SLS_C_MASTER];
  wire clock_polarity = ctrl_q[`SLS_C_CLOCK_POLARITY];
  wire clock_phase = ctrl_q[`SLS_C_CLOCK_PHASE];
  wire lsb = ctrl_q[`SLS_C_LSB];
  wire sel_out_en = ctrl_q[`SLS_C_SEL_OUT_EN];
  wire [1:0] rate = {ctrl_q[`SLS_C_RATE_HI], ctrl_q[`SLS_C_RATE_LO]};

  // Master edge enable
  wire tick;
  sls_rate_div u_div (
    .clock(clock),
    .sys_rst(sys_rst),
    .run(busy_q & master_select & en),
    .rate(rate),
    .tick(tick)
  );

  // Register decode, used for each register
  function hit;
    input [9:0] idx;
    input [9:0] reg_idx;
    begin
      hit = (idx == reg_idx);
    end
  endfunction

  // Shift one bit in, direction set by bit order
  function [7:0] shf;
    input [7:0] sh;
    input b;
    input lsb_first;
    begin
      shf = lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
    end
  endfunction

  // Shift in ones for every bit still owed on an aborted byte
  function [7:0] fill_ones;
    input [7:0] sh;
    input [3:0] left;
    input lsb_first;
    integer i;
    begin
      fill_ones = sh;
      for (i = 0; i < 8; i = i + 1) begin
        if (i < left) begin
          fill_ones = shf(fill_ones, 1'b1, lsb_first);
        end
      end
    end
  endfunction

  // Bus access: one request answered per ack, bus writes on the low byte
  wire acc = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = acc & wb_we_i & wb_sel_i[0];
  wire [9:0] idx = wb_adr_i[11:2];
  wire wr_ctrl = wr & hit(idx, `SLS_IDX_CTRL);
  wire wr_stat = wr & hit(idx, `SLS_IDX_STAT);
  wire wr_data = wr & hit(idx, `SLS_IDX_DATA);
  wire wr_ien = wr & hit(idx, `SLS_IDX_IEN);
  wire [7:0] wd = wb_dat_i[7:0];

  // Mode fault: master, enabled, detection on, select pulled low
  wire mf_ev = en & master_select & ~fault_det_dis_q & ~ss_n_s;
  // Config change while enabled kills the byte in flight
  wire cfg_abort = wr_ctrl & en & (wd[5:0] != ctrl_q[5:0]);
  // Slave is selected only through the select pin
  wire slv_sel = en & ~master_select & ~ss_n_s;
  // Slave deselected part way through a byte
  wire slv_abort = ~master_select & busy_q & ss_n_s & (edge_q != 4'h0);

  // Edge events on the shift clock
  wire edge_ev = busy_q & en & (master_select ? tick : (slv_sel & (sclk_s != sclk_prev_q)));
  wire in_bit = master_select ? miso_s : mosi_s;
  wire samp = (edge_q[0] == clock_phase);
  wire last = (edge_q == `SLS_LAST_EDGE);
  wire done_ev = edge_ev & last;
  wire [7:0] done_byte = shf(shreg_q, samp ? in_bit : sin_q, lsb);
  wire out_bit = lsb ? shreg_q[0] : shreg_q[7];
  // Shifts completed so far, for the ones fill
  wire [3:0] shifts = clock_phase ? ((edge_q - 4'h1) >> 1) : (edge_q >> 1);

  // Flag events
  wire data_take = wr_data & ~complete_flag_q;
  wire write_collision_flag_ev = data_take & (busy_q | slv_sel);
  wire load_ev = data_take & ~busy_q & ~slv_sel;
  wire ovf_ev = done_ev & complete_flag_q;

  // Control register; mode fault overrides a same-cycle software write
  always @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q <= `SLS_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wd;
      end
      if (mf_ev) begin
        ctrl_q[`SLS_C_MASTER] <= 1'b0;
        ctrl_q[`SLS_C_EN] <= 1'b0;
      end
    end
  end

  // Status flags: set wins over a software clear written as zero
  always @(posedge clock) begin
    if (sys_rst) begin
      complete_flag_q <= 1'b0;
      collision_flag_q <= 1'b0;
      ovf_q <= 1'b0;
      mode_fault_q <= 1'b0;
      fault_det_dis_q <= 1'b0;
    end else begin
      // A byte finishing in the clearing cycle keeps the flag set
      complete_flag_q <= done_ev | (complete_flag_q & ~(wr_stat & ~wd[`SLS_S_DONE]));
      collision_flag_q <= write_collision_flag_ev | (collision_flag_q & ~(wr_stat & ~wd[`SLS_S_COLL]));
      ovf_q <= ovf_ev | (ovf_q & ~(wr_stat & ~wd[`SLS_S_OVF]));
      mode_fault_q <= mf_ev | (mode_fault_q & ~(wr_stat & ~wd[`SLS_S_FAULT]));
      if (wr_stat) begin
        fault_det_dis_q <= wd[`SLS_S_FAULT_DIS];
      end
    end
  end

  // Interrupt enables
  always @(posedge clock) begin
    if (sys_rst) begin
      ien_q <= `SLS_RST_IEN;
    end else if (wr_ien) begin
      ien_q <= {wd[`SLS_I_GLOBAL], wd[`SLS_I_SERIAL]};
    end
  end

  // Shifter: loads, edges, completion and aborts
  always @(posedge clock) begin
    if (sys_rst) begin
      shreg_q <= `SLS_RST_BYTE;
      rxbuf_q <= `SLS_RST_BYTE;
      busy_q <= 1'b0;
      edge_q <= 4'h0;
      sin_q <= 1'b0;
      lvl_q <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      if (mf_ev || cfg_abort || !en) begin
        // Forced idle; data already shifted stays put
        busy_q <= 1'b0;
        edge_q <= 4'h0;
        lvl_q <= 1'b0;
      end else if (slv_abort) begin
        // Owed bits read as ones, no completion
        shreg_q <= fill_ones(shreg_q, `SLS_BITS - shifts, lsb);
        busy_q <= 1'b0;
        edge_q <= 4'h0;
      end else if (load_ev) begin
        // No holding buffer: straight into the shifter
        shreg_q <= wd;
        busy_q <= master_select;
        edge_q <= 4'h0;
        lvl_q <= 1'b0;
      end else if (!master_select && !busy_q) begin
        // Slave waits for select; byte boundary counted from here
        busy_q <= slv_sel;
        edge_q <= 4'h0;
      end else if (!master_select && !slv_sel) begin
        // Deselected at a byte boundary
        busy_q <= 1'b0;
        edge_q <= 4'h0;
      end else if (edge_ev) begin
        edge_q <= edge_q + 4'h1;
        lvl_q <= ~lvl_q;
        if (done_ev) begin
          // Full duplex byte done; receive buffer keeps the older byte on overrun
          shreg_q <= done_byte;
          if (!complete_flag_q) begin
            rxbuf_q <= done_byte;
          end
          busy_q <= ~master_select;
          edge_q <= 4'h0;
          lvl_q <= 1'b0;
        end else if (samp) begin
          sin_q <= in_bit;
        end else if (edge_q != 4'h0) begin
          // First edge with late sampling only presents the first bit
          shreg_q <= shf(shreg_q, sin_q, lsb);
        end
      end
    end
  end

  // Bus answer: ack one cycle after the request, dropped the next
  always @(posedge clock) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      rdat_q <= 8'h00;
    end else begin
      ack_q <= acc;
      if (hit(idx, `SLS_IDX_CTRL)) begin
        rdat_q <= ctrl_q;
      end else if (hit(idx, `SLS_IDX_STAT)) begin
        rdat_q <= {complete_flag_q, collision_flag_q, ovf_q, mode_fault_q, fault_det_dis_q, 3'h0};
      end else if (hit(idx, `SLS_IDX_DATA)) begin
        rdat_q <= rxbuf_q;
      end else if (hit(idx, `SLS_IDX_IEN)) begin
        rdat_q <= {6'h00, ien_q};
      end else begin
        // Unmapped words read zero
        rdat_q <= 8'h00;
      end
    end
  end

  // Pin drivers and interrupt, all registered
  always @(posedge clock) begin
    if (sys_rst) begin
      sclk_o_q <= 1'b0;
      sclk_oe_q <= 1'b0;
      mosi_o_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_o_q <= 1'b0;
      miso_oe_q <= 1'b0;
      ss_o_q <= 1'b1;
      ss_oe_q <= 1'b0;
      gpio_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      // Master drives clock and data out
      sclk_o_q <= clock_polarity ^ lvl_q;
      sclk_oe_q <= en & master_select;
      mosi_o_q <= out_bit;
      mosi_oe_q <= en & master_select;
      // Slave drives its output only while selected
      miso_o_q <= out_bit;
      miso_oe_q <= slv_sel;
      // Automatic select low for the byte, high when idle
      ss_o_q <= ~busy_q;
      ss_oe_q <= en & master_select & fault_det_dis_q & sel_out_en;
      // Pin released to the port when unused by the unit
      gpio_q <= ~en | (master_select & fault_det_dis_q & ~sel_out_en);
      irq_q <= ien_q[`SLS_I_GLOBAL] & ien_q[`SLS_I_SERIAL] & (complete_flag_q | ovf_q | mode_fault_q);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h000000, rdat_q};
  assign sclk_o = sclk_o_q;
  assign sclk_oe = sclk_oe_q;
  assign mosi_o = mosi_o_q;
  assign mosi_oe = mosi_oe_q;
  assign miso_o = miso_o_q;
  assign miso_oe = miso_oe_q;
  assign ss_n_o = ss_o_q;
  assign ss_n_oe = ss_oe_q;
  assign ss_gpio_mode = gpio_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

// ### hw/sls_defs.vh
// Constants for the serial link block: register indices, bit positions,
// reset values and shift clock divider counts.
// Assumes a 32-bit classic Wishbone bus, one register per aligned word.
`ifndef SLS_DEFS_VH
`define SLS_DEFS_VH

// Register indices; byte address is four times the index
`define SLS_IDX_CTRL 10'h0f3
`define SLS_IDX_STAT 10'h0f4
`define SLS_IDX_DATA 10'h0f5
`define SLS_IDX_IEN 10'h0f6

// Control register bits
`define SLS_C_SEL_OUT_EN 7
`define SLS_C_EN 6
`define SLS_C_LSB 5
`define SLS_C_MASTER 4
`define SLS_C_CLOCK_POLARITY 3
`define SLS_C_CLOCK_PHASE 2
`define SLS_C_RATE_HI 1
`define SLS_C_RATE_LO 0

// Status register bits
`define SLS_S_DONE 7
`define SLS_S_COLL 6
`define SLS_S_OVF 5
`define SLS_S_FAULT 4
`define SLS_S_FAULT_DIS 3

// Interrupt enable register bits
`define SLS_I_GLOBAL 1
`define SLS_I_SERIAL 0

// Reset values
`define SLS_RST_BYTE 8'h00
`define SLS_RST_IEN 2'h0

// Half periods of the shift clock less one, in peripheral clocks (divide 16..128)
`define SLS_HALF_16 6'h07
`define SLS_HALF_32 6'h0f
`define SLS_HALF_64 6'h1f
`define SLS_HALF_128 6'h3f

// Sixteen shift clock edges per byte; index of the last one
`define SLS_LAST_EDGE 4'hf
`define SLS_BITS 4'h8

`endif

// ### hw/sls_sync2.v
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clock; only stage two is read.
`timescale 1ns/1ns
`default_nettype none
module sls_sync2 #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Asynchronous inputs
  input wire [WIDTH-1:0] async_in,
  // Synchronised outputs
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q; // First stage, read by stage two only
  reg [WIDTH-1:0] sync_q; // Second stage

  // Chain of two flops; idle pins are high, so reset to ones
  always @(posedge clock) begin
    if (sys_rst) begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ### hw/sls_rate_div.v
// Shift clock divider: one-cycle tick at each shift clock edge.
// Assumes run stays high for a whole byte; counter restarts when low.
`timescale 1ns/1ns
`default_nettype none
`include "sls_defs.vh"
module sls_rate_div (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Control
  input wire run,
  input wire [1:0] rate,
  // Edge enable
  output wire tick
);
  reg [5:0] cnt_q; // Cycles into current half period
  reg tick_q; // Registered edge pulse
  reg [5:0] half; // Terminal count for the selected rate

  // Two ticks per shift clock period
  always @* begin
    case (rate)
      2'h0: half = `SLS_HALF_16;
      2'h1: half = `SLS_HALF_32;
      2'h2: half = `SLS_HALF_64;
      default: half = `SLS_HALF_128;
    endcase
  end

  // Count half periods; restart so the first edge lands a half period in
  always @(posedge clock) begin
    if (sys_rst || !run) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else if (cnt_q == half) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 6'h01;
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

// ### tb/sls_serial_link_monitor.sv
// Checker bound to the serial link unit, ports only.
// Assumes software writes reach control, status and enables by Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "sls_defs.vh"
module sls_serial_link_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins
  input wire logic sclk_o,
  input wire logic sclk_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_n_i,
  input wire logic ss_n_o,
  input wire logic ss_n_oe,
  input wire logic ss_gpio_mode,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Shadows of fields that hardware never changes
  logic [1:0] rate_q, ien_q;
  logic sel_out_q, dis_q, seen_q, sclk_p;
  logic [6:0] gap_q;
  wire tk = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
  wire [9:0] idx = wb_adr_i[11:2];
  // Toggle of the driven shift clock
  wire tg = sclk_oe && (sclk_o != sclk_p);
  // Gap counter saturates so idle time never wraps into a false match
  always @(posedge clock) begin
    if (sys_rst) begin
      rate_q <= 2'h0;
      ien_q <= 2'h0;
      sel_out_q <= 1'b0;
      dis_q <= 1'b0;
      seen_q <= 1'b0;
      sclk_p <= 1'b0;
      gap_q <= 7'h00;
    end else begin
      if (tk && idx == `SLS_IDX_CTRL) begin
        rate_q <= wb_dat_i[1:0];
        sel_out_q <= wb_dat_i[7];
      end
      if (tk && idx == `SLS_IDX_STAT) dis_q <= wb_dat_i[3];
      if (tk && idx == `SLS_IDX_IEN) ien_q <= wb_dat_i[1:0];
      sclk_p <= sclk_o;
      gap_q <= tg ? 7'h00 : (gap_q == 7'h7f ? gap_q : gap_q + 7'h01);
      // First toggle of a byte has no reference gap
      seen_q <= ss_n_o ? 1'b0 : (tg ? 1'b1 : seen_q);
    end
  end
  property p_ack_once;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("bus answer not a single pulse");
  property p_rst_vals;
    $fell(sys_rst) |-> !irq && !sclk_oe && !mosi_oe && !miso_oe && !ss_n_oe && ss_gpio_mode;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("outputs wrong after reset");
  property p_stat_rsv;
    wb_ack_o && !wb_we_i && idx == `SLS_IDX_STAT |-> wb_dat_o[2:0] == 3'h0 && wb_dat_o[31:8] == 24'h0;
  endproperty
  a_stat_rsv: assert property (p_stat_rsv) else $error("reserved status bits set");
  property p_irq_en;
    irq |-> $past(ien_q) == 2'h3;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("request without both enables");
  property p_fault_in;
    ss_n_oe |-> $past(dis_q) && $past(sel_out_q);
  endproperty
  a_fault_in: assert property (p_fault_in) else $error("select driven while an input");
  property p_gpio;
    ss_n_oe |-> !ss_gpio_mode;
  endproperty
  a_gpio: assert property (p_gpio) else $error("select both general and driven");
  property p_auto;
    tg && dis_q && sel_out_q |-> ss_n_oe && !$past(ss_n_o);
  endproperty
  a_auto: assert property (p_auto) else $error("auto select not low in byte");
  property p_rate;
    tg && seen_q |-> gap_q == ((7'h08 << rate_q) - 7'h01);
  endproperty
  a_rate: assert property (p_rate) else $error("shift clock half period wrong");
  property p_fault;
    (!dis_q && !ss_n_i) [*4] |-> ##[0:3] (!sclk_oe && !mosi_oe);
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault left unit driving");
endmodule
bind sls_serial_link sls_serial_link_monitor sls_serial_link_monitor_i (.clock, .sys_rst,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .sclk_o, .sclk_oe, .mosi_oe, .miso_oe, .ss_n_i, .ss_n_o, .ss_n_oe, .ss_gpio_mode, .irq);
`default_nettype wire

// ### tb/sls_partner.sv
// Far-side slave model: mode 0, most significant bit first.
// Assumes it sees the wire levels and the bench clock for edge finding.
`timescale 1ns/1ns
`default_nettype none
module sls_partner (
  // Clock
  input wire logic clock,
  // Wire levels
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  // Bench commands
  input wire logic fault,
  input wire logic [7:0] tx,
  // Driven pins and received byte
  output logic miso,
  output logic pull,
  output logic [7:0] rx
);
  logic [7:0] sh;
  logic sp, ssp;
  // Pulls select low only when the bench asks for a fault
  assign pull = fault;
  initial begin
    miso = 1'b0;
    sh = 8'h00;
    rx = 8'h00;
    sp = 1'b0;
    ssp = 1'b1;
  end
  // Edges found one clock late; half periods are far longer
  always @(posedge clock) begin
    sp <= sclk;
    ssp <= ss_n;
    if (ss_n) miso <= ~miso; // Released line keeps changing
    else if (ssp) begin
      sh <= tx;
      miso <= tx[7];
    end else if (sclk && !sp) rx <= {rx[6:0], mosi};
    else if (!sclk && sp) begin
      miso <= sh[6];
      sh <= {sh[6:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

// ### tb/test_sls_serial_link.sv
// Bench for the serial link unit: bus tasks, queue checker, slave model.
// Assumes the unit acks one cycle after a request and pins resolve here.
`timescale 1ns/1ns
`default_nettype none
`include "sls_defs.vh"
module test_sls_serial_link;
  localparam logic [11:0] A_C = {`SLS_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_S = {`SLS_IDX_STAT, 2'h0};
  localparam logic [11:0] A_D = {`SLS_IDX_DATA, 2'h0};
  localparam logic [11:0] A_I = {`SLS_IDX_IEN, 2'h0};
  // Bench-driven inputs
  logic clock = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h1;
  logic tog = 1'b0, fault = 1'b0;
  logic [7:0] ptx = 8'h00, b, p, e, r;
  // Design outputs and wire levels
  wire [31:0] dat_o;
  wire ack, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe, gpio, irq;
  wire p_miso, pull;
  wire [7:0] prx;
  // Undriven lines show a changing pattern, select has a pull-up
  wire sclk_w = sclk_oe ? sclk_o : tog;
  wire mosi_w = mosi_oe ? mosi_o : tog;
  wire miso_w = miso_oe ? miso_o : p_miso;
  wire ss_w = ss_n_oe ? ss_n_o : !pull;
  int seed = 19, checks = 0, bad_count = 0, h, d;
  time t0;
  logic [31:0] exq[$];
  always #50 clock = ~clock;
  always @(posedge clock) tog <= ~tog;
  sls_serial_link sls_serial_link_i (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_w),
    .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .ss_gpio_mode(gpio), .irq(irq));
  sls_partner sls_partner_i (.clock(clock), .sclk(sclk_w), .mosi(mosi_w), .ss_n(ss_w), .fault(fault),
    .tx(ptx), .miso(p_miso), .pull(pull), .rx(prx));
  task tally_and_finish;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, s, x);
    end
  endtask
  // One classic cycle; held until ack is sampled high
  task bus(input logic w, input logic [11:0] a, input logic [7:0] v);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, v};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      tally_and_finish;
    end
    @(posedge clock);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] v);
    bus(1'b1, a, v);
  endtask
  // Read notes its expectation for the watcher
  task rd(input logic [11:0] a, input logic [7:0] x);
    exq.push_back({24'h0, x});
    bus(1'b0, a, 8'h00);
  endtask
  // Interrupt request doubles as completion signal
  task wirq;
    int n;
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clock);
      n++;
      if (n > 3000) begin
        bad_count++;
        tally_and_finish;
      end
    end
  endtask
  task settle;
    repeat (4) @(posedge clock);
  endtask
  // Watcher: each read answer against the oldest note
  always @(posedge clock) begin
    if (ack === 1'b1 && we === 1'b0 && exq.size() > 0) chk(dat_o, exq.pop_front());
  end
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(A_S, 8'h00);
    rd(A_D, 8'h00);
    rd(12'h000, 8'h00);
    wr(A_S, 8'h0f);
    rd(A_S, 8'h08);
    wr(A_I, 8'h03);
    // Every rate; last one also collides mid-byte
    for (r = 8'h00; r < 8'h04; r++) begin
      b = $random(seed);
      p = $random(seed);
      ptx <= p;
      wr(A_C, 8'hd0 | r);
      wr(A_D, b);
      t0 = $time;
      if (r == 8'h03) wr(A_D, ~b);
      wirq;
      h = 16 * (8 << r);
      d = int'(($time - t0) / 100);
      chk(32'(d > h - 5 && d < h + 5), 32'h1);
      chk(prx, b);
      rd(A_D, p);
      e = (r == 8'h03) ? 8'hc8 : 8'h88;
      rd(A_S, e);
      wr(A_D, 8'h5a);
      settle;
      chk(ss_n_o, 1'b1);
      wr(A_I, 8'h01);
      settle;
      chk(irq, 1'b0);
      wr(A_I, 8'h03);
      settle;
      chk(irq, 1'b1);
      rd(A_S, e);
      wr(A_S, 8'h08);
      rd(A_S, 8'h08);
      settle;
      chk(irq, 1'b0);
    end
    wr(A_C, 8'h50);
    settle;
    chk(gpio, 1'b1);
    wr(A_C, 8'hd0);
    settle;
    chk(gpio, 1'b0);
    wr(A_S, 8'h00);
    settle;
    chk(ss_n_oe, 1'b0);
    fault <= 1'b1;
    wirq;
    fault <= 1'b0;
    rd(A_S, 8'h10);
    rd(A_C, 8'h80);
    wr(A_S, 8'h08);
    wr(A_C, 8'hc0);
    settle;
    chk(ss_n_oe, 1'b0);
    chk(gpio, 1'b0);
    // Slave selected; free-running clock gives back to back bytes
    fault <= 1'b1;
    wirq;
    settle;
    chk(miso_oe, 1'b1);
    repeat (40) @(posedge clock);
    fault <= 1'b0;
    settle;
    chk(miso_oe, 1'b0);
    rd(A_S, 8'ha8);
    tally_and_finish;
  end
endmodule
`default_nettype wire
